// ---- mrd_decoder.sv ----
// Purpose: decodes the special-register selector and the mod/rm addressing form
// Assumes: fetch presents one instruction per in_valid with its fields aligned
// Notes: one cycle latency; only mod 00 and mod 11 forms are resolved
`timescale 1ns/1ps
module mrd_decoder (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [7:0] modrm,
    input wire logic has_modrm,
    input wire mrd_pkg::mrd_cls_t spec_cls,
    input wire logic opcode_w,
    input wire logic addr32,
    input wire logic data32,
    output logic out_valid,
    output mrd_pkg::mrd_spec_t spec_reg,
    output logic spec_invalid,
    output logic modrm_used,
    output logic reg_direct,
    output logic form_known,
    output mrd_pkg::mrd_seg_t seg,
    output mrd_pkg::mrd_areg_t base_reg,
    output mrd_pkg::mrd_areg_t index_reg,
    output mrd_pkg::mrd_disp_t disp_size,
    output logic sib_follows,
    output mrd_pkg::mrd_opsz_t opnd_size
);
    typedef struct packed {
        mrd_pkg::mrd_seg_t seg;
        mrd_pkg::mrd_areg_t base;
        mrd_pkg::mrd_areg_t index;
        mrd_pkg::mrd_disp_t disp;
        logic sib;
    } mrd_form_t;

    // mod 00 row for either address size
    function automatic mrd_form_t mod0_row(input logic [2:0] rm, input logic a32);
        mrd_form_t f;
        f = '{mrd_pkg::SEG_DATA, mrd_pkg::AREG_NONE, mrd_pkg::AREG_NONE,
              mrd_pkg::DISP_NONE, 1'b0};
        if (!a32) begin
            case (rm)
                3'h0: begin
                    f.base = mrd_pkg::AREG_BX;
                    f.index = mrd_pkg::AREG_SI;
                end
                3'h1: begin
                    f.base = mrd_pkg::AREG_BX;
                    f.index = mrd_pkg::AREG_DI;
                end
                3'h2: begin
                    f.seg = mrd_pkg::SEG_STACK;
                    f.base = mrd_pkg::AREG_BP;
                    f.index = mrd_pkg::AREG_SI;
                end
                3'h3: begin
                    f.seg = mrd_pkg::SEG_STACK;
                    f.base = mrd_pkg::AREG_BP;
                    f.index = mrd_pkg::AREG_DI;
                end
                3'h4: f.base = mrd_pkg::AREG_SI;
                3'h5: f.base = mrd_pkg::AREG_DI;
                3'h6: f.disp = mrd_pkg::DISPLACEMENT_16;
                default: f.base = mrd_pkg::AREG_BX;
            endcase
        end else begin
            case (rm)
                3'h0: f.base = mrd_pkg::AREG_EAX;
                3'h1: f.base = mrd_pkg::AREG_ECX;
                3'h2: f.base = mrd_pkg::AREG_EDX;
                3'h3: f.base = mrd_pkg::AREG_EBX;
                3'h4: begin
                    f.seg = mrd_pkg::SEG_NONE;
                    f.sib = 1'b1;
                end
                3'h5: f.disp = mrd_pkg::DISPLACEMENT_32;
                3'h6: f.base = mrd_pkg::AREG_ESI;
                default: f.base = mrd_pkg::AREG_EDI;
            endcase
        end
        return f;
    endfunction

    mrd_sel_if sel ();

    mrd_eee_dec u_eee (
        .sel(sel)
    );

    logic [1:0] mod_f;
    logic [2:0] rm_f;
    mrd_form_t form;

    logic out_valid_r, out_valid_nxt;
    mrd_pkg::mrd_spec_t spec_r, spec_nxt;
    logic invalid_r, invalid_nxt;
    logic used_r, used_nxt;
    logic direct_r, direct_nxt;
    logic known_r, known_nxt;
    mrd_form_t form_r, form_nxt;
    mrd_pkg::mrd_opsz_t opsz_r, opsz_nxt;

    assign sel.selector = modrm[mrd_pkg::SEL_HI:mrd_pkg::SEL_LO];
    assign sel.cls = has_modrm ? spec_cls : mrd_pkg::CLS_NONE;
    assign mod_f = modrm[mrd_pkg::MOD_HI:mrd_pkg::MOD_LO];
    assign rm_f = modrm[mrd_pkg::RM_HI:mrd_pkg::RM_LO];
    assign form = mod0_row(rm_f, addr32);

    always_comb begin
        out_valid_nxt = in_valid;
        spec_nxt = spec_r;
        invalid_nxt = invalid_r;
        used_nxt = used_r;
        direct_nxt = direct_r;
        known_nxt = known_r;
        form_nxt = form_r;
        opsz_nxt = opsz_r;
        if (in_valid) begin
            spec_nxt = sel.spec;
            invalid_nxt = !sel.valid;
            // implied form, byte left in stream
            used_nxt = has_modrm;
            if (!opcode_w) begin
                opsz_nxt = mrd_pkg::OPSZ_8;
            end else begin
                opsz_nxt = data32 ? mrd_pkg::OPSZ_32 : mrd_pkg::OPSZ_16;
            end
            form_nxt = '{mrd_pkg::SEG_NONE, mrd_pkg::AREG_NONE, mrd_pkg::AREG_NONE,
                         mrd_pkg::DISP_NONE, 1'b0};
            direct_nxt = 1'b0;
            known_nxt = 1'b0;
            // form chosen by mod and rm
            if (has_modrm) begin
                if (mod_f == mrd_pkg::MOD_INDIRECT) begin
                    form_nxt = form;
                    known_nxt = 1'b1;
                end else if (mod_f == mrd_pkg::MOD_REGISTER) begin
                    // register form sized by width bit
                    direct_nxt = 1'b1;
                    known_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_valid_r <= 1'b0;
            spec_r <= mrd_pkg::SPEC_NONE;
            invalid_r <= 1'b0;
            used_r <= 1'b0;
            direct_r <= 1'b0;
            known_r <= 1'b0;
            form_r <= '{mrd_pkg::SEG_NONE, mrd_pkg::AREG_NONE, mrd_pkg::AREG_NONE,
                        mrd_pkg::DISP_NONE, 1'b0};
            opsz_r <= mrd_pkg::OPSZ_8;
        end else begin
            out_valid_r <= out_valid_nxt;
            spec_r <= spec_nxt;
            invalid_r <= invalid_nxt;
            used_r <= used_nxt;
            direct_r <= direct_nxt;
            known_r <= known_nxt;
            form_r <= form_nxt;
            opsz_r <= opsz_nxt;
        end
    end

    assign out_valid = out_valid_r;
    assign spec_reg = spec_r;
    assign spec_invalid = invalid_r;
    assign modrm_used = used_r;
    assign reg_direct = direct_r;
    assign form_known = known_r;
    assign seg = form_r.seg;
    assign base_reg = form_r.base;
    assign index_reg = form_r.index;
    assign disp_size = form_r.disp;
    assign sib_follows = form_r.sib;
    assign opnd_size = opsz_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence s_take_mod0(logic [2:0] r, logic a);
        in_valid && has_modrm && mod_f == 2'h0 && rm_f == r && addr32 == a;
    endsequence

    sequence s_take_sel(mrd_pkg::mrd_cls_t c, logic [2:0] v);
        in_valid && has_modrm && spec_cls == c && modrm[5:3] == v;
    endsequence

    chk_ctl_sel_map: assert property (
        s_take_sel(mrd_pkg::CLS_CONTROL, 3'h2) |=> spec_reg == mrd_pkg::CONTROL_REG_2
            && !spec_invalid)
        else $error("control selector 010 misdecoded");
    chk_dbg_sel_map: assert property (
        s_take_sel(mrd_pkg::CLS_DEBUG, 3'h6) |=> spec_reg == mrd_pkg::DEBUG_REG_6)
        else $error("debug selector 110 misdecoded");
    chk_test_sel_map: assert property (
        s_take_sel(mrd_pkg::CLS_TEST, 3'h5) |=> spec_reg == mrd_pkg::TEST_REG_5)
        else $error("test selector 101 misdecoded");
    chk_bad_sel_flag: assert property (
        s_take_sel(mrd_pkg::CLS_CONTROL, 3'h1) or s_take_sel(mrd_pkg::CLS_TEST, 3'h0)
            |=> out_valid && spec_invalid && spec_reg == mrd_pkg::SPEC_NONE)
        else $error("unlisted selector not flagged");
    chk_implied_form: assert property (
        in_valid && !has_modrm |=> !modrm_used && !form_known && !spec_invalid)
        else $error("implied form consumed addressing byte");
    chk_row0_16: assert property (
        s_take_mod0(3'h0, 1'b0) |=> seg == mrd_pkg::SEG_DATA
            && base_reg == mrd_pkg::AREG_BX && index_reg == mrd_pkg::AREG_SI)
        else $error("mod00 rm000 16-bit form wrong");
    chk_row2_stack: assert property (
        s_take_mod0(3'h2, 1'b0) |=> seg == mrd_pkg::SEG_STACK && base_reg == mrd_pkg::AREG_BP)
        else $error("mod00 rm010 16-bit form wrong");
    chk_row4_sib: assert property (
        s_take_mod0(3'h4, 1'b1) |=> sib_follows && form_known)
        else $error("scaled-index byte not expected");
    chk_row5_disp: assert property (
        s_take_mod0(3'h5, 1'b1) |=> disp_size == mrd_pkg::DISPLACEMENT_32
            && base_reg == mrd_pkg::AREG_NONE)
        else $error("mod00 rm101 32-bit form wrong");
    chk_row6_disp: assert property (
        s_take_mod0(3'h6, 1'b0) |=> disp_size == mrd_pkg::DISPLACEMENT_16)
        else $error("mod00 rm110 16-bit form wrong");
    chk_width_byte: assert property (
        in_valid && !opcode_w |=> opnd_size == mrd_pkg::OPSZ_8)
        else $error("width bit 0 not byte operand");
    chk_width_full: assert property (
        in_valid && has_modrm && mod_f == mrd_pkg::MOD_REGISTER && opcode_w && data32
            |=> reg_direct && opnd_size == mrd_pkg::OPSZ_32)
        else $error("full width operand size wrong");
endmodule

// ---- mrd_eee_dec.sv ----
// Purpose: maps a three-bit selector and class to a special register
// Assumes: class none means no special-register move
// Notes: combinational
`timescale 1ns/1ps
module mrd_eee_dec (
    mrd_sel_if.dec sel
);
    always_comb begin
        sel.spec = mrd_pkg::SPEC_NONE;
        case (sel.cls)
            mrd_pkg::CLS_CONTROL: begin
                case (sel.selector)
                    3'h0: sel.spec = mrd_pkg::CONTROL_REG_0;
                    3'h2: sel.spec = mrd_pkg::CONTROL_REG_2;
                    3'h3: sel.spec = mrd_pkg::CONTROL_REG_3;
                    3'h4: sel.spec = mrd_pkg::CONTROL_REG_4;
                    default: sel.spec = mrd_pkg::SPEC_NONE;
                endcase
            end
            mrd_pkg::CLS_DEBUG: begin
                case (sel.selector)
                    3'h0: sel.spec = mrd_pkg::DEBUG_REG_0;
                    3'h1: sel.spec = mrd_pkg::DEBUG_REG_1;
                    3'h2: sel.spec = mrd_pkg::DEBUG_REG_2;
                    3'h3: sel.spec = mrd_pkg::DEBUG_REG_3;
                    3'h6: sel.spec = mrd_pkg::DEBUG_REG_6;
                    3'h7: sel.spec = mrd_pkg::DEBUG_REG_7;
                    default: sel.spec = mrd_pkg::SPEC_NONE;
                endcase
            end
            mrd_pkg::CLS_TEST: begin
                case (sel.selector)
                    3'h3: sel.spec = mrd_pkg::TEST_REG_3;
                    3'h4: sel.spec = mrd_pkg::TEST_REG_4;
                    3'h5: sel.spec = mrd_pkg::TEST_REG_5;
                    3'h6: sel.spec = mrd_pkg::TEST_REG_6;
                    3'h7: sel.spec = mrd_pkg::TEST_REG_7;
                    default: sel.spec = mrd_pkg::SPEC_NONE;
                endcase
            end
            default: sel.spec = mrd_pkg::SPEC_NONE;
        endcase
        sel.valid = (sel.cls == mrd_pkg::CLS_NONE) || (sel.spec != mrd_pkg::SPEC_NONE);
    end
endmodule

// ---- mrd_fetch_model.sv ----
// Purpose: fetch-stage stand-in that presents one instruction's fields to the decoder
// Assumes: bench sets the request fields just after the falling edge
// Notes: stale stream bytes show on modrm whenever no addressing byte is offered
`timescale 1ns/1ps
module mrd_fetch_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire mrd_pkg::mrd_cls_t req_cls,
    input wire logic [7:0] req_byte,
    input wire logic req_has,
    input wire logic req_w,
    input wire logic req_a32,
    input wire logic req_d32,
    output logic in_valid,
    output logic [7:0] modrm,
    output logic has_modrm,
    output mrd_pkg::mrd_cls_t spec_cls,
    output logic opcode_w,
    output logic addr32,
    output logic data32
);
    logic [7:0] junk_r;

    // stream keeps moving, so an unused byte lane never holds still
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            junk_r <= 8'h5a;
        end else begin
            junk_r <= ~junk_r + 8'h01;
        end
    end

    // implied forms carry no addressing byte
    assign modrm = (req_valid && req_has) ? req_byte : junk_r;
    assign in_valid = req_valid;
    assign has_modrm = req_has;
    assign spec_cls = req_cls;
    assign opcode_w = req_w;
    assign addr32 = req_a32;
    assign data32 = req_d32;
endmodule

// ---- mrd_pkg.sv ----
// Purpose: shared types and constants of the addressing-byte decoder
// Assumes: one core clock, byte fields already aligned by fetch
// Notes: register ids are unique across classes
package mrd_pkg;
    localparam int SEL_HI = 5;
    localparam int SEL_LO = 3;
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int RM_HI = 2;
    localparam int RM_LO = 0;

    localparam logic [1:0] MOD_INDIRECT = 2'h0;
    localparam logic [1:0] MOD_REGISTER = 2'h3;

    typedef enum logic [1:0] {
        CLS_NONE = 2'b00,
        CLS_CONTROL = 2'b01,
        CLS_DEBUG = 2'b10,
        CLS_TEST = 2'b11
    } mrd_cls_t;

    typedef enum logic [3:0] {
        SPEC_NONE = 4'b0000,
        CONTROL_REG_0 = 4'b0001,
        CONTROL_REG_2 = 4'b0010,
        CONTROL_REG_3 = 4'b0011,
        CONTROL_REG_4 = 4'b0100,
        DEBUG_REG_0 = 4'b0101,
        DEBUG_REG_1 = 4'b0110,
        DEBUG_REG_2 = 4'b0111,
        DEBUG_REG_3 = 4'b1000,
        DEBUG_REG_6 = 4'b1001,
        DEBUG_REG_7 = 4'b1010,
        TEST_REG_3 = 4'b1011,
        TEST_REG_4 = 4'b1100,
        TEST_REG_5 = 4'b1101,
        TEST_REG_6 = 4'b1110,
        TEST_REG_7 = 4'b1111
    } mrd_spec_t;

    typedef enum logic [3:0] {
        AREG_NONE = 4'b0000,
        AREG_BX = 4'b0001,
        AREG_BP = 4'b0010,
        AREG_SI = 4'b0011,
        AREG_DI = 4'b0100,
        AREG_EAX = 4'b0101,
        AREG_ECX = 4'b0110,
        AREG_EDX = 4'b0111,
        AREG_EBX = 4'b1000,
        AREG_ESI = 4'b1001,
        AREG_EDI = 4'b1010
    } mrd_areg_t;

    typedef enum logic [1:0] {
        SEG_NONE = 2'b00,
        SEG_DATA = 2'b01,
        SEG_STACK = 2'b10
    } mrd_seg_t;

    typedef enum logic [1:0] {
        DISP_NONE = 2'b00,
        DISPLACEMENT_16 = 2'b01,
        DISPLACEMENT_32 = 2'b10
    } mrd_disp_t;

    typedef enum logic [1:0] {
        OPSZ_8 = 2'b00,
        OPSZ_16 = 2'b01,
        OPSZ_32 = 2'b10
    } mrd_opsz_t;
endpackage

// ---- mrd_sel_if.sv ----
// Purpose: carries the special-register selector to its decoder and back
// Assumes: purely combinational path
// Notes: none
`timescale 1ns/1ps
interface mrd_sel_if;
    mrd_pkg::mrd_cls_t cls;
    logic [2:0] selector;
    mrd_pkg::mrd_spec_t spec;
    logic valid;
    modport dec (input cls, input selector, output spec, output valid);
    modport user (output cls, output selector, input spec, input valid);
endinterface

// ---- x86_modrm_eee_decoder_test.sv ----
// Purpose: self-checking bench of the selector and addressing-form decoder
// Assumes: one-cycle answer, results hold while no instruction is taken
// Notes: mod 01/10 forms are only checked as unresolved
`timescale 1ns/1ps
module x86_modrm_eee_decoder_test;
    logic clock, rstn, go, has, w, a32, d32, in_valid, has_modrm, opcode_w, addr32, data32;
    logic [7:0] req_byte, modrm;
    mrd_pkg::mrd_cls_t cls, spec_cls;
    logic out_valid, spec_invalid, modrm_used, reg_direct, form_known, sib_follows;
    mrd_pkg::mrd_spec_t spec_reg, e_spec;
    mrd_pkg::mrd_seg_t seg, e_seg;
    mrd_pkg::mrd_areg_t base_reg, index_reg;
    mrd_pkg::mrd_disp_t disp_size, e_disp;
    mrd_pkg::mrd_opsz_t opnd_size, e_opsz;
    logic pend_v, e_inv, e_used, e_dir, e_known, e_sib;
    integer miscompares, comparisons, cycles, i, k;
    logic [31:0] seed, r;
    logic [7:0] e_ab;

    mrd_fetch_model i_mrd_fetch_model (.clock(clock), .rstn(rstn), .req_valid(go),
        .req_cls(cls), .req_byte(req_byte), .req_has(has), .req_w(w), .req_a32(a32),
        .req_d32(d32), .in_valid(in_valid), .modrm(modrm), .has_modrm(has_modrm),
        .spec_cls(spec_cls), .opcode_w(opcode_w), .addr32(addr32), .data32(data32));

    mrd_decoder i_mrd_decoder (.clock(clock), .rstn(rstn), .in_valid(in_valid),
        .modrm(modrm), .has_modrm(has_modrm), .spec_cls(spec_cls), .opcode_w(opcode_w),
        .addr32(addr32), .data32(data32), .out_valid(out_valid), .spec_reg(spec_reg),
        .spec_invalid(spec_invalid), .modrm_used(modrm_used), .reg_direct(reg_direct),
        .form_known(form_known), .seg(seg), .base_reg(base_reg), .index_reg(index_reg),
        .disp_size(disp_size), .sib_follows(sib_follows), .opnd_size(opnd_size));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function automatic mrd_pkg::mrd_spec_t exp_spec(mrd_pkg::mrd_cls_t c, logic [2:0] s);
        exp_spec = mrd_pkg::SPEC_NONE;
        if (c == mrd_pkg::CLS_CONTROL && s == 3'h0) exp_spec = mrd_pkg::CONTROL_REG_0;
        if (c == mrd_pkg::CLS_CONTROL && s >= 3'h2 && s <= 3'h4)
            exp_spec = mrd_pkg::mrd_spec_t'(4'(mrd_pkg::CONTROL_REG_2) + 4'(s - 3'h2));
        if (c == mrd_pkg::CLS_DEBUG && s <= 3'h3)
            exp_spec = mrd_pkg::mrd_spec_t'(4'(mrd_pkg::DEBUG_REG_0) + 4'(s));
        if (c == mrd_pkg::CLS_DEBUG && s >= 3'h6)
            exp_spec = mrd_pkg::mrd_spec_t'(4'(mrd_pkg::DEBUG_REG_6) + 4'(s - 3'h6));
        if (c == mrd_pkg::CLS_TEST && s >= 3'h3)
            exp_spec = mrd_pkg::mrd_spec_t'(4'(mrd_pkg::TEST_REG_3) + 4'(s - 3'h3));
    endfunction

    function automatic mrd_pkg::mrd_seg_t exp_seg(logic [1:0] md, logic [2:0] rm, logic a);
        exp_seg = mrd_pkg::SEG_NONE;
        if (md == 2'h0) begin
            if (a) exp_seg = (rm == 3'h4) ? mrd_pkg::SEG_NONE : mrd_pkg::SEG_DATA;
            else exp_seg = (rm == 3'h2 || rm == 3'h3) ? mrd_pkg::SEG_STACK : mrd_pkg::SEG_DATA;
        end
    endfunction

    // base in the upper nibble, index in the lower one
    function automatic logic [7:0] exp_areg(logic [1:0] md, logic [2:0] rm, logic a);
        logic [7:0] v;
        v = {4'(mrd_pkg::AREG_NONE), 4'(mrd_pkg::AREG_NONE)};
        if (md == 2'h0 && a) begin
            case (rm)
                3'h0: v[7:4] = 4'(mrd_pkg::AREG_EAX);
                3'h1: v[7:4] = 4'(mrd_pkg::AREG_ECX);
                3'h2: v[7:4] = 4'(mrd_pkg::AREG_EDX);
                3'h3: v[7:4] = 4'(mrd_pkg::AREG_EBX);
                3'h6: v[7:4] = 4'(mrd_pkg::AREG_ESI);
                3'h7: v[7:4] = 4'(mrd_pkg::AREG_EDI);
                default: v[7:4] = 4'(mrd_pkg::AREG_NONE);
            endcase
        end else if (md == 2'h0) begin
            case (rm)
                3'h0, 3'h1, 3'h7: v[7:4] = 4'(mrd_pkg::AREG_BX);
                3'h2, 3'h3: v[7:4] = 4'(mrd_pkg::AREG_BP);
                3'h4: v[7:4] = 4'(mrd_pkg::AREG_SI);
                3'h5: v[7:4] = 4'(mrd_pkg::AREG_DI);
                default: v[7:4] = 4'(mrd_pkg::AREG_NONE);
            endcase
            if (rm == 3'h0 || rm == 3'h2) v[3:0] = 4'(mrd_pkg::AREG_SI);
            if (rm == 3'h1 || rm == 3'h3) v[3:0] = 4'(mrd_pkg::AREG_DI);
        end
        return v;
    endfunction

    task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            miscompares = miscompares + 1;
        end
    endtask

    task automatic compare_all();
        check("out_valid", 4'(pend_v), 4'(out_valid));
        check("spec_reg", 4'(e_spec), 4'(spec_reg));
        check("spec_invalid", 4'(e_inv), 4'(spec_invalid));
        check("modrm_used", 4'(e_used), 4'(modrm_used));
        check("reg_direct", 4'(e_dir), 4'(reg_direct));
        check("form_known", 4'(e_known), 4'(form_known));
        check("opnd_size", 4'(e_opsz), 4'(opnd_size));
        if (e_known) begin
            check("seg", 4'(e_seg), 4'(seg));
            check("disp_size", 4'(e_disp), 4'(disp_size));
            check("sib_follows", 4'(e_sib), 4'(sib_follows));
            check("base_reg", e_ab[7:4], 4'(base_reg));
            check("index_reg", e_ab[3:0], 4'(index_reg));
        end
    endtask

    task automatic step(input logic v, input mrd_pkg::mrd_cls_t c, input logic [7:0] m,
            input logic h, input logic ww, input logic aa, input logic dd);
        @(negedge clock);
        compare_all();
        go = v;
        cls = c;
        req_byte = m;
        has = h;
        w = ww;
        a32 = aa;
        d32 = dd;
        pend_v = v;
        if (v) begin
            e_used = h;
            e_dir = h && m[7:6] == 2'h3;
            e_known = h && (m[7:6] == 2'h0 || m[7:6] == 2'h3);
            e_spec = exp_spec(h ? c : mrd_pkg::CLS_NONE, m[5:3]);
            e_inv = h && c != mrd_pkg::CLS_NONE && e_spec == mrd_pkg::SPEC_NONE;
            e_seg = exp_seg(m[7:6], m[2:0], aa);
            e_ab = exp_areg(m[7:6], m[2:0], aa);
            e_disp = mrd_pkg::DISP_NONE;
            if (m[7:6] == 2'h0 && aa && m[2:0] == 3'h5) e_disp = mrd_pkg::DISPLACEMENT_32;
            if (m[7:6] == 2'h0 && !aa && m[2:0] == 3'h6) e_disp = mrd_pkg::DISPLACEMENT_16;
            e_sib = m[7:6] == 2'h0 && aa && m[2:0] == 3'h4;
            e_opsz = !ww ? mrd_pkg::OPSZ_8 : (dd ? mrd_pkg::OPSZ_32 : mrd_pkg::OPSZ_16);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ceiling well above the roughly five hundred cycles the tests need
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end

    initial begin
        {go, has, w, a32, d32, pend_v, e_inv, e_used, e_dir, e_known, e_sib} = '0;
        req_byte = 8'h00;
        e_ab = 8'h00;
        cls = mrd_pkg::CLS_NONE;
        e_spec = mrd_pkg::SPEC_NONE;
        e_seg = mrd_pkg::SEG_NONE;
        e_disp = mrd_pkg::DISP_NONE;
        e_opsz = mrd_pkg::OPSZ_8;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        seed = 32'he374f528;
        rstn = 1'b0;
        repeat (10) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        step(1'b1, mrd_pkg::CLS_CONTROL, 8'h10, 1'b1, 1'b1, 1'b0, 1'b0);
        step(1'b0, mrd_pkg::CLS_NONE, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        check("base_reg", 4'(mrd_pkg::AREG_BX), 4'(base_reg));
        check("index_reg", 4'(mrd_pkg::AREG_SI), 4'(index_reg));
        $display("test walk done");
        // every selector of every class back to back, odd and even mods
        for (i = 0; i < 32; i++) begin
            step(1'b1, mrd_pkg::mrd_cls_t'(i[4:3]), {i[0], i[0], i[2:0], i[3:1]}, 1'b1,
                i[1], i[2], i[3]);
        end
        $display("test selectors done");
        // all mod 00 rows across address size, width bit and data size
        for (i = 0; i < 64; i++) begin
            step(1'b1, mrd_pkg::CLS_NONE, {2'h0, 3'h5, i[2:0]}, 1'b1, i[3], i[4],
                i[5]);
        end
        $display("test mod00 done");
        // implied forms with a control class must not flag an invalid selector
        for (i = 0; i < 8; i++) begin
            step(1'b1, mrd_pkg::CLS_CONTROL, 8'hff, 1'b0, i[0], i[1], i[2]);
        end
        $display("test implied done");
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            k = $random(seed);
            step(r[9:8] != 2'h0, mrd_pkg::mrd_cls_t'(r[1:0]), k[7:0], r[2] | r[3], r[4],
                r[5], r[6]);
        end
        step(1'b0, mrd_pkg::CLS_NONE, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        step(1'b0, mrd_pkg::CLS_NONE, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("test random done");
        summarize();
    end
endmodule
